// ### rsc_pkg.sv
// constants and types for the reset and pin-interrupt system control block
package rsc_pkg;
  // register indices on the internal byte register port
  localparam logic [1:0] IDX_PIN_IRQ   = 2'h0;
  localparam logic [1:0] IDX_RST_CAUSE = 2'h1;
  localparam logic [1:0] IDX_FORCE_RST = 2'h2;

  // pin_interrupt_status_control fields
  localparam int BIT_PULL_DIS = 6;
  localparam int BIT_POL      = 5;
  localparam int BIT_PIN_EN   = 4;
  localparam int BIT_FLAG     = 3;
  localparam int BIT_ACK      = 2;
  localparam int BIT_REQ_EN   = 1;
  localparam int BIT_MODE     = 0;
  localparam logic [7:0] PIN_IRQ_RESET = 8'h00;

  // reset_cause_status fields
  localparam int BIT_POR      = 7;
  localparam int BIT_WDOG     = 5;
  localparam int BIT_ILL_OP   = 4;
  localparam int BIT_ILL_ADDR = 3;
  localparam int BIT_LOW_V    = 1;

  // debug_force_reset fields
  localparam int         BIT_FORCE_RST = 0;
  localparam logic [7:0] FORCE_RST_READ = 8'h00;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;

  typedef struct packed {
    logic       pull_dis;
    logic       polarity;
    logic       pin_en;
    logic       req_en;
    logic       mode;
    logic       flag;
    logic       pin_prev;
    logic [7:0] cause;
    logic [7:0] rdata;
    logic       force_rst;
  } rsc_state_s;
endpackage

// ### rsc_sync_if.sv
// carrier between the pin synchroniser and the control block
`timescale 1ns/1ns
`default_nettype none
interface rsc_sync_if;
  logic pin_sync;
  modport src (output pin_sync);
  modport dst (input  pin_sync);
endinterface
`default_nettype wire

// ### rsc_pin_sync.sv
// two-flop synchroniser for the interrupt request pin
`timescale 1ns/1ns
`default_nettype none
module rsc_pin_sync (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // pin and result
  input  wire logic pin_i,
  rsc_sync_if.src   sync
);
  logic meta_q;
  logic stable_q;

  // reset to the idle-high level so a pulled-up pin makes no false edge
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      meta_q   <= 1'b1;
      stable_q <= 1'b1;
    end else if (ce_i) begin
      meta_q   <= pin_i;
      stable_q <= meta_q;
    end
  end

  assign sync.pin_sync = stable_q;
endmodule
`default_nettype wire

// ### rsc_sysctl.sv
// reset cause, force reset and external interrupt pin control
// Notes on behaviour
// (R1) with pin enabled, pull disable 0 turns pull device on, 1 turns it off
// (R2) polarity 0 detects falling/low, 1 detects rising/high
// (R3) rising polarity with pull on makes the pull a pulldown
// (R4) mode bit picks edge only or edge plus level detection
// (R5) pin enable set lets the pin request interrupts; clear disables it
// (R6) flag is read-only, reads 1 after a detected request event
// (R7) in level mode flag sets on edge and stays while pin asserted
// (R8) flag and request enable both set raise the interrupt request
// (R9) writing acknowledge clears flag unless level holds; acknowledge reads 0
// (R10) watchdog cause set after watchdog reset; blocked when watchdog disabled
// (R11) illegal opcode cause set after illegal opcode; stop illegal if disabled
// (R12) background entry instruction illegal when background mode disabled
// (R13) illegal address cause set after access to unimplemented address
// (R14) low voltage cause set after enabled low-voltage trip and after power-on
// (R15) power-on sets both power-on and low voltage causes
// (R16) each reset records only its own causes; software cannot write them
// (R17) force reset register ignores user writes and reads 0x00
// (R18) debug host writing 1 to bit 0 forces a full reset
// (R19) host holds mode-select pin high for user mode, low for debug mode
// (R20) pull device used when enabled, pulling up or down by polarity
`timescale 1ns/1ns
`default_nettype none
module rsc_sysctl (
  // clock, reset, enable
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  // register port
  input  wire logic [1:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_dbg_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // interrupt pin
  input  wire logic       irq_pin_i,
  output logic            pull_up_en_o,
  output logic            pull_down_en_o,
  output logic            irq_req_o,
  // reset sources, sampled while nrst_i is low
  input  wire logic       por_i,
  input  wire logic       wdog_timeout_i,
  input  wire logic       watchdog_enable_setting_i,
  input  wire logic       illegal_opcode_i,
  input  wire logic       stop_exec_i,
  input  wire logic       stop_instruction_enable_i,
  input  wire logic       background_entry_instruction_i,
  input  wire logic       background_mode_enable_i,
  input  wire logic       illegal_address_i,
  input  wire logic       low_voltage_trip_i,
  input  wire logic       low_voltage_reset_enable_i,
  // reset request to the system reset controller
  output logic            reset_req_o
);
  rsc_pkg::rsc_state_s s_q;
  rsc_pkg::rsc_state_s s_d;
  rsc_sync_if          sync_if ();

  rsc_pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (irq_pin_i),
    .sync      (sync_if.src)
  );

  // pin view
  logic       pin_level;
  logic       pin_asserted;
  logic       prev_asserted;
  logic       edge_seen;
  logic       level_hold;
  logic       pull_active;

  // reset cause qualification
  logic       wdog_rst;
  logic       stop_illegal;
  logic       bkgd_illegal;
  logic       illegal_opcode_cause_rst;
  logic       illegal_address_cause_rst;
  logic       lowv_rst;
  logic [7:0] cause_now;

  // register decode
  logic       wr_irq;
  logic       wr_force;
  logic       rd_irq;
  logic       rd_cause;
  logic       rd_force;
  logic       ack;
  logic       force_hit;
  logic [7:0] irq_view;

  always_comb begin
    pin_level     = sync_if.pin_sync;
    // asserted level follows polarity so detection is active-high afterwards
    pin_asserted  = pin_level ^ ~s_q.polarity;  // [R2]
    // the stored sample is a raw level judged with the current polarity, so a
    // polarity write cannot turn a stale sample into an edge
    prev_asserted = s_q.pin_prev ^ ~s_q.polarity;  // [R2]
    edge_seen     = s_q.pin_en && pin_asserted && !prev_asserted;  // [R5]
    level_hold    = s_q.pin_en && s_q.mode && pin_asserted;  // [R4] [R7]
  end

  always_comb begin
    wdog_rst     = wdog_timeout_i && watchdog_enable_setting_i;  // [R10]
    stop_illegal = stop_exec_i && !stop_instruction_enable_i;  // [R11]
    bkgd_illegal = background_entry_instruction_i && !background_mode_enable_i;  // [R12]
    illegal_opcode_cause_rst     = illegal_opcode_i || stop_illegal || bkgd_illegal;  // [R11] [R12]
    illegal_address_cause_rst     = illegal_address_i;  // [R13]
    lowv_rst     = por_i || (low_voltage_trip_i && low_voltage_reset_enable_i);  // [R14] [R15]
    // causes not raised by this reset read 0 afterwards
    cause_now                        = rsc_pkg::BYTE_ZERO;  // [R16]
    cause_now[rsc_pkg::BIT_POR]      = por_i;  // [R15]
    cause_now[rsc_pkg::BIT_WDOG]     = wdog_rst;  // [R10]
    cause_now[rsc_pkg::BIT_ILL_OP]   = illegal_opcode_cause_rst;  // [R11] [R12]
    cause_now[rsc_pkg::BIT_ILL_ADDR] = illegal_address_cause_rst;  // [R13]
    cause_now[rsc_pkg::BIT_LOW_V]    = lowv_rst;  // [R14]
  end

  always_comb begin
    wr_irq    = reg_wr_i && reg_addr_i == rsc_pkg::IDX_PIN_IRQ;
    // debug-only write strobe; user writes never reach it
    wr_force  = reg_wr_i && reg_dbg_i && reg_addr_i == rsc_pkg::IDX_FORCE_RST;  // [R17]
    rd_irq    = reg_rd_i && reg_addr_i == rsc_pkg::IDX_PIN_IRQ;
    rd_cause  = reg_rd_i && reg_addr_i == rsc_pkg::IDX_RST_CAUSE;
    rd_force  = reg_rd_i && reg_addr_i == rsc_pkg::IDX_FORCE_RST;
    ack       = wr_irq && reg_wdata_i[rsc_pkg::BIT_ACK];  // [R9]
    force_hit = wr_force && reg_wdata_i[rsc_pkg::BIT_FORCE_RST];  // [R18]
    // acknowledge is write-only, so its bit stays 0 in the read view
    irq_view                        = rsc_pkg::BYTE_ZERO;  // [R9]
    irq_view[rsc_pkg::BIT_PULL_DIS] = s_q.pull_dis;
    irq_view[rsc_pkg::BIT_POL]      = s_q.polarity;
    irq_view[rsc_pkg::BIT_PIN_EN]   = s_q.pin_en;
    irq_view[rsc_pkg::BIT_FLAG]     = s_q.flag;  // [R6]
    irq_view[rsc_pkg::BIT_REQ_EN]   = s_q.req_en;
    irq_view[rsc_pkg::BIT_MODE]     = s_q.mode;
  end

  always_comb begin
    s_d = s_q;
    if (wr_irq) begin
      s_d.pull_dis = reg_wdata_i[rsc_pkg::BIT_PULL_DIS];
      s_d.polarity = reg_wdata_i[rsc_pkg::BIT_POL];
      s_d.pin_en   = reg_wdata_i[rsc_pkg::BIT_PIN_EN];
      s_d.req_en   = reg_wdata_i[rsc_pkg::BIT_REQ_EN];
      s_d.mode     = reg_wdata_i[rsc_pkg::BIT_MODE];
    end
    // a disabled pin parks at its asserted raw level so enabling makes no edge
    if (s_q.pin_en) begin
      s_d.pin_prev = pin_level;
    end else begin
      s_d.pin_prev = s_d.polarity;
    end
    // new event or held level wins over acknowledge
    if (edge_seen || level_hold) begin
      s_d.flag = 1'b1;  // [R6] [R7]
    end else if (ack) begin
      s_d.flag = 1'b0;  // [R9]
    end
    // cause register holds between resets; no write path exists
    s_d.cause     = s_q.cause;  // [R16]
    s_d.force_rst = force_hit;  // [R18]
    // read data stands one cycle, then returns to 0
    s_d.rdata     = rsc_pkg::BYTE_ZERO;
    if (rd_irq) begin
      s_d.rdata = irq_view;  // [R6] [R9]
    end else if (rd_cause) begin
      s_d.rdata = s_q.cause;  // [R16]
    end else if (rd_force) begin
      s_d.rdata = rsc_pkg::FORCE_RST_READ;  // [R17]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      s_q.pull_dis  <= rsc_pkg::PIN_IRQ_RESET[rsc_pkg::BIT_PULL_DIS];
      s_q.polarity  <= rsc_pkg::PIN_IRQ_RESET[rsc_pkg::BIT_POL];
      s_q.pin_en    <= rsc_pkg::PIN_IRQ_RESET[rsc_pkg::BIT_PIN_EN];
      s_q.req_en    <= rsc_pkg::PIN_IRQ_RESET[rsc_pkg::BIT_REQ_EN];
      s_q.mode      <= rsc_pkg::PIN_IRQ_RESET[rsc_pkg::BIT_MODE];
      s_q.flag      <= rsc_pkg::PIN_IRQ_RESET[rsc_pkg::BIT_FLAG];
      // parked at the asserted raw level of the reset polarity
      s_q.pin_prev  <= rsc_pkg::PIN_IRQ_RESET[rsc_pkg::BIT_POL];
      s_q.rdata     <= rsc_pkg::BYTE_ZERO;
      s_q.force_rst <= 1'b0;
      // synchronous reset: causes of this reset captured, others cleared
      s_q.cause     <= cause_now;  // [R10] [R11] [R12] [R13] [R14] [R15] [R16]
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    reg_rdata_o    = s_q.rdata;
    // pull only on a pin in use and not handed to an external device
    pull_active    = s_q.pin_en && !s_q.pull_dis;  // [R1]
    // pullup normally, becomes pulldown for rising polarity
    pull_up_en_o   = pull_active && !s_q.polarity;  // [R20]
    pull_down_en_o = pull_active && s_q.polarity;  // [R3] [R20]
    irq_req_o      = s_q.flag && s_q.req_en;  // [R8]
    reset_req_o    = s_q.force_rst;  // [R18]
  end
endmodule
`default_nettype wire

// ### rsc_sysctl_properties.sv
// port assertions for the system control block
`timescale 1ns/1ns
`default_nettype none
module rsc_sysctl_properties (
  // watched ports
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic       ce_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic       reg_dbg_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       pull_up_en_o,
  input wire logic       pull_down_en_o,
  input wire logic       irq_req_o,
  input wire logic       reset_req_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic rd_pin;
  logic wr_pin;
  logic dbg_force;
  assign rd_pin = reg_rd_i && ce_i && reg_addr_i == 2'h0;
  assign wr_pin = reg_wr_i && ce_i && reg_addr_i == 2'h0;
  assign dbg_force = reg_wr_i && ce_i && reg_dbg_i && reg_addr_i == 2'h2 && reg_wdata_i[0];
  a_force_needs_dbg: assert property (reset_req_o |-> $past(dbg_force)) else $error("stray reset");
  a_force_fires: assert property (dbg_force |=> reset_req_o) else $error("no reset");
  a_force_reads_zero: assert property (reg_rd_i && ce_i && reg_addr_i == 2'h2 |=> reg_rdata_o == 8'h00)
    else $error("force reg read");
  a_ack_reads_zero: assert property (rd_pin |=> !reg_rdata_o[2]) else $error("ack bit read");
  a_irq_flag_tie: assert property (rd_pin |=> (reg_rdata_o[3] && reg_rdata_o[1]) == $past(irq_req_o))
    else $error("irq request");
  a_pull_up_cfg: assert property (wr_pin |=> pull_up_en_o == ($past(reg_wdata_i[6:4]) == 3'b001))
    else $error("pullup");
  a_pull_down_cfg: assert property (wr_pin |=> pull_down_en_o == ($past(reg_wdata_i[6:4]) == 3'b011))
    else $error("pulldown");
  a_pull_excl: assert property (!(pull_up_en_o && pull_down_en_o)) else $error("both pulls");
  a_reset_quiet: assert property ($rose(nrst_i) |-> !irq_req_o && !pull_up_en_o && !pull_down_en_o)
    else $error("reset state");
endmodule
bind rsc_sysctl rsc_sysctl_properties u_props (.clk_sys_i, .nrst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_dbg_i, .reg_wdata_i, .reg_rdata_o, .pull_up_en_o, .pull_down_en_o, .irq_req_o, .reset_req_o);
`default_nettype wire

// ### rsc_pin_model.sv
// interrupt pin source with pull devices
`timescale 1ns/1ns
`default_nettype none
module rsc_pin_model (
  // control
  input  wire logic clk_sys_i,
  input  wire logic drive_i,
  input  wire logic level_i,
  input  wire logic pull_up_en_i,
  input  wire logic pull_down_en_i,
  // pin
  output logic      pin_o
);
  logic float_q = 1'b0;
  // an unpulled, undriven pin wanders instead of holding its last value
  always @(posedge clk_sys_i) float_q <= !float_q;
  always_comb begin
    if (drive_i) pin_o = level_i;
    else if (pull_up_en_i) pin_o = 1'b1;
    else if (pull_down_en_i) pin_o = 1'b0;
    else pin_o = float_q;
  end
endmodule
`default_nettype wire

// ### rsc_sysctl_tb.sv
// testbench for the system control block
`timescale 1ns/1ns
`default_nettype none
module rsc_sysctl_tb;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic        wr = 1'b0, rd = 1'b0, dbg = 1'b0, drv = 1'b1, lvl = 1'b1;
  logic [7:0]  wdata = 8'h00;
  logic [10:0] src = 11'h001;
  logic [7:0]  rdata;
  logic        pin, pu, pd, irq, rreq;
  logic        background_mode_select_pin = 1'b0;
  int          failures = 0;
  int          cmp_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  rsc_pin_model pm (.clk_sys_i, .drive_i(drv), .level_i(lvl), .pull_up_en_i(pu), .pull_down_en_i(pd), .pin_o(pin));
  rsc_sysctl dut (.clk_sys_i, .nrst_i, .ce_i(1'b1), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_dbg_i(dbg), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .irq_pin_i(pin), .pull_up_en_o(pu),
    .pull_down_en_o(pd), .irq_req_o(irq), .por_i(src[0]), .wdog_timeout_i(src[1]),
    .watchdog_enable_setting_i(src[2]), .illegal_opcode_i(src[3]), .stop_exec_i(src[4]),
    .stop_instruction_enable_i(src[5]), .background_entry_instruction_i(src[6]),
    .background_mode_enable_i(src[7]), .illegal_address_i(src[8]), .low_voltage_trip_i(src[9]),
    .low_voltage_reset_enable_i(src[10]), .reset_req_o(rreq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d, input logic g);
    @(posedge clk_sys_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    dbg <= g;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    rd <= 1'b0;
    dbg <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] e);
    acc(1'b0, 2'h0, 8'h00, 1'b0);
    chk(rdata, e, "pin control");
  endtask
  task automatic wrd(input logic [7:0] d, input logic [7:0] e);
    acc(1'b1, 2'h0, d, 1'b0);
    rdc(e);
  endtask
  task automatic rst(input logic [10:0] s);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    src <= s;
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
  endtask
  // the synchroniser plus detect stage needs three edges; four leaves margin
  task automatic pin_set(input logic d, input logic v);
    @(posedge clk_sys_i);
    drv <= d;
    lvl <= v;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic t_causes;
    logic [10:0] s [11] = '{11'h001, 11'h006, 11'h002, 11'h008, 11'h010, 11'h030, 11'h040, 11'h0c0,
                            11'h600, 11'h200, 11'h100};
    logic [7:0]  e [11] = '{8'h82, 8'h20, 8'h00, 8'h10, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h00, 8'h08};
    for (int i = 0; i < 11; i++) begin
      rst(s[i]);
      acc(1'b0, 2'h1, 8'h00, 1'b0);
      chk(rdata, e[i], "reset cause");
    end
    acc(1'b1, 2'h1, 8'hff, 1'b0);
    acc(1'b0, 2'h1, 8'h00, 1'b0);
    chk(rdata, 8'h08, "cause after write");
  endtask
  task automatic t_force;
    acc(1'b1, 2'h2, 8'h01, 1'b0);
    chk({7'h00, rreq}, 8'h00, "user force");
    acc(1'b0, 2'h2, 8'h00, 1'b1);
    chk(rdata, 8'h00, "force read");
    acc(1'b1, 2'h2, 8'h01, 1'b1);
    chk({7'h00, rreq}, 8'h01, "debug force");
    // host asks for user mode right after the forced reset write
    background_mode_select_pin <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk({7'h00, rreq}, 8'h00, "force pulse");
    // the system controller answers the request with a reset of no listed cause
    rst(11'h000);
    acc(1'b0, 2'h1, 8'h00, 1'b0);
    chk(rdata, 8'h00, "forced cause");
  endtask
  task automatic t_pin;
    wrd(8'h12, 8'h12);
    chk({6'h00, pu, pd}, 8'h02, "pull falling");
    pin_set(1'b1, 1'b0);
    chk({7'h00, irq}, 8'h01, "request");
    rdc(8'h1a);
    wrd(8'h16, 8'h12);
    pin_set(1'b0, 1'b0);
    wrd(8'h32, 8'h32);
    chk({6'h00, pu, pd}, 8'h01, "pull rising");
    pin_set(1'b1, 1'b1);
    rdc(8'h3a);
    wrd(8'h36, 8'h32);
    pin_set(1'b0, 1'b0);
    wrd(8'h33, 8'h33);
    pin_set(1'b1, 1'b1);
    wrd(8'h37, 8'h3b);
    pin_set(1'b0, 1'b0);
    wrd(8'h37, 8'h33);
    acc(1'b1, 2'h0, 8'h50, 1'b0);
    chk({6'h00, pu, pd}, 8'h00, "pull off");
    // request enable stays on so any detection on the floating pin would show
    acc(1'b1, 2'h0, 8'h03, 1'b0);
    wrd(8'h07, 8'h03);
    repeat (8) @(posedge clk_sys_i);
    rdc(8'h03);
    chk({7'h00, irq}, 8'h00, "no request");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    t_causes();
    t_force();
    t_pin();
    finish_test();
  end
endmodule
`default_nettype wire
